// [src/ccd_exec.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Clearing a file register writes 00h to it and sets the zero flag.
// - A call pushes the address of the next instruction, PC plus one.
// - A call loads its 11-bit immediate into PC bits 10 to 0.
// - A call takes PC bits 12 and 11 from latch bits 4 and 3.
// - A call is 10 0kkk kkkk kkkk and changes no status flag.
// - A call takes two cycles because the prefetched word is dropped.
// - Clearing the accumulator writes 00h to it and sets zero, in one cycle.
// - The watchdog restart zeroes the watchdog counter in one cycle.
// - The watchdog restart also zeroes the watchdog prescaler.
// - The watchdog restart sets expiry and sleep bits, no other flag.
// - Register decrement subtracts one and sets zero from the result.
// - With destination 0 the decrement result goes to the accumulator.
// - With destination 1 the decrement result goes back to the file.
// - Decrement takes file addresses 0 to 127 and a one-bit destination.
module ccd_exec
    import ccd_pkg::*;
(
    input  wire logic                           ref_clk_i,
    input  wire logic                           srst_i,
    input  wire logic                           instr_valid_i,
    input  wire logic [ccd_pkg::CCD_INSTR_W-1:0] instr_i,
    input  wire logic [ccd_pkg::CCD_PC_W-1:0]    pc_i,
    input  wire logic [ccd_pkg::CCD_DATA_W-1:0]  latch_i,
    input  wire logic [ccd_pkg::CCD_DATA_W-1:0]  file_rdata_i,
    output logic                                instr_ready_o,
    output logic                                file_we_o,
    output logic [ccd_pkg::CCD_FADDR_W-1:0]      file_addr_o,
    output logic [ccd_pkg::CCD_DATA_W-1:0]       file_wdata_o,
    output logic                                w_we_o,
    output logic [ccd_pkg::CCD_DATA_W-1:0]       w_wdata_o,
    output logic                                z_we_o,
    output logic                                z_o,
    output logic                                stack_push_o,
    output logic [ccd_pkg::CCD_PC_W-1:0]         stack_top_o,
    output logic                                pc_load_o,
    output logic [ccd_pkg::CCD_PC_W-1:0]         pc_target_o,
    output logic                                flush_o,
    output logic                                wdt_clear_o,
    output logic                                prescaler_clear_o,
    output logic                                expiry_bit_set_o,
    output logic                                sleep_status_bit_set_o
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    ccd_dec_if dif ();

    ccd_decode u_decode (
        .instr_i (instr_i),
        .dif     (dif)
    );

    ccd_state_t              state_q, state_d;
    logic                    ready_q, ready_d;
    logic                    accept;
    logic [CCD_DATA_W-1:0]   dec_res;

    // Request taken only while the execute stage is ready
    assign accept  = instr_valid_i && ready_q;
    assign dec_res = file_rdata_i - CCD_ONE;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------

    // Next state: a call spends one extra cycle dropping the prefetch
    always_comb begin
        state_d = state_q;
        ready_d = ready_q;
        unique case (state_q)
            CCD_ST_EXEC: begin
                if (accept && dif.is_call) begin
                    state_d = CCD_ST_FLUSH;
                    ready_d = 1'b0;
                end
            end
            CCD_ST_FLUSH: begin
                state_d = CCD_ST_EXEC;
                ready_d = 1'b1;
            end
            default: begin
                state_d = CCD_ST_EXEC;
                ready_d = 1'b1;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= CCD_ST_EXEC;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            ready_q <= ready_d;
        end
    end

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    logic                    fwe_d, fwe_q;
    logic [CCD_FADDR_W-1:0]  fadr_d, fadr_q;
    logic [CCD_DATA_W-1:0]   fdat_d, fdat_q;
    logic                    wwe_d, wwe_q;
    logic [CCD_DATA_W-1:0]   wdat_d, wdat_q;
    logic                    zwe_d, zwe_q;
    logic                    z_d, z_q;
    logic                    push_d, push_q;
    logic [CCD_PC_W-1:0]     tos_d, tos_q;
    logic                    pcl_d, pcl_q;
    logic [CCD_PC_W-1:0]     pct_d, pct_q;
    logic                    wdt_d, wdt_q;

    // Result of the accepted instruction; all strobes last one cycle
    always_comb begin
        fwe_d  = 1'b0;
        fadr_d = fadr_q;
        fdat_d = fdat_q;
        wwe_d  = 1'b0;
        wdat_d = wdat_q;
        zwe_d  = 1'b0;
        z_d    = z_q;
        push_d = 1'b0;
        tos_d  = tos_q;
        pcl_d  = 1'b0;
        pct_d  = pct_q;
        wdt_d  = 1'b0;
        if (accept) begin
            if (dif.is_fclr) begin
                fwe_d  = 1'b1;
                fadr_d = dif.faddr;
                fdat_d = CCD_ZERO;
                zwe_d  = 1'b1;
                z_d    = 1'b1;
            end else if (dif.is_wclr) begin
                wwe_d  = 1'b1;
                wdat_d = CCD_ZERO;
                zwe_d  = 1'b1;
                z_d    = 1'b1;
            end else if (dif.is_dec) begin
                zwe_d  = 1'b1;
                z_d    = (dec_res == CCD_ZERO);
                fadr_d = dif.faddr;
                if (dif.dest) begin
                    fwe_d  = 1'b1;
                    fdat_d = dec_res;
                end else begin
                    wwe_d  = 1'b1;
                    wdat_d = dec_res;
                end
            end else if (dif.is_call) begin
                push_d = 1'b1;
                tos_d  = pc_i + CCD_PC_ONE;
                pcl_d  = 1'b1;
                pct_d  = {latch_i[CCD_LATCH_HI:CCD_LATCH_LO],
                          dif.target};
            end else if (dif.is_wdt) begin
                wdt_d  = 1'b1;
            end
        end
    end

    // Output registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fwe_q  <= 1'b0;
            fadr_q <= '0;
            fdat_q <= CCD_ZERO;
            wwe_q  <= 1'b0;
            wdat_q <= CCD_ZERO;
            zwe_q  <= 1'b0;
            z_q    <= 1'b0;
            push_q <= 1'b0;
            tos_q  <= '0;
            pcl_q  <= 1'b0;
            pct_q  <= '0;
            wdt_q  <= 1'b0;
        end else begin
            fwe_q  <= fwe_d;
            fadr_q <= fadr_d;
            fdat_q <= fdat_d;
            wwe_q  <= wwe_d;
            wdat_q <= wdat_d;
            zwe_q  <= zwe_d;
            z_q    <= z_d;
            push_q <= push_d;
            tos_q  <= tos_d;
            pcl_q  <= pcl_d;
            pct_q  <= pct_d;
            wdt_q  <= wdt_d;
        end
    end

    // Ports straight from flops
    assign instr_ready_o          = ready_q;
    assign file_we_o              = fwe_q;
    assign file_addr_o            = fadr_q;
    assign file_wdata_o           = fdat_q;
    assign w_we_o                 = wwe_q;
    assign w_wdata_o              = wdat_q;
    assign z_we_o                 = zwe_q;
    assign z_o                    = z_q;
    assign stack_push_o           = push_q;
    assign stack_top_o            = tos_q;
    assign pc_load_o              = pcl_q;
    assign pc_target_o            = pct_q;
    assign flush_o                = pcl_q;
    assign wdt_clear_o            = wdt_q;
    assign prescaler_clear_o      = wdt_q;
    assign expiry_bit_set_o       = wdt_q;
    assign sleep_status_bit_set_o = wdt_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_call_taken;
        accept && dif.is_call;
    endsequence
    sequence s_call_gap;
        !instr_ready_o && flush_o ##1 instr_ready_o && !flush_o;
    endsequence

    a_fclr_zero: assert property (accept && dif.is_fclr |=>
        file_we_o && file_wdata_o == CCD_ZERO && z_we_o && z_o)
        else $error("file clear did not write zero and set Z");
    a_fclr_addr: assert property (
        accept && instr_i[13:CCD_FCLR_LSB] == CCD_FCLR_OP |=>
        file_addr_o == $past(instr_i[CCD_FADDR_W-1:0]))
        else $error("file clear address wrong");
    a_call_push: assert property (s_call_taken |=>
        stack_push_o && stack_top_o == $past(pc_i) + CCD_PC_ONE)
        else $error("call pushed wrong return address");
    a_call_low_target: assert property (s_call_taken |=>
        pc_load_o && pc_target_o[CCD_TGT_W-1:0] ==
        $past(instr_i[CCD_TGT_W-1:0]))
        else $error("call low target wrong");
    a_call_high_bits: assert property (s_call_taken |=>
        pc_target_o[CCD_PC_W-1:CCD_TGT_W] ==
        $past(latch_i[CCD_LATCH_HI:CCD_LATCH_LO]))
        else $error("call upper PC bits wrong");
    a_call_no_flags: assert property (s_call_taken |=>
        !z_we_o && !expiry_bit_set_o && !sleep_status_bit_set_o)
        else $error("call touched a status flag");
    a_call_two_cycles: assert property (s_call_taken |=> s_call_gap)
        else $error("call did not take two cycles");
    a_wclr_zero: assert property (
        accept && instr_i == CCD_WCLR_CODE |=>
        w_we_o && w_wdata_o == CCD_ZERO && z_we_o && z_o && instr_ready_o)
        else $error("accumulator clear wrong");
    // Pulse stays high after one cycle only if another restart was taken
    a_wdt_clear: assert property (
        accept && instr_i == CCD_WDT_CODE |=>
        (wdt_clear_o && prescaler_clear_o) ##1
        (wdt_clear_o == $past(accept && instr_i == CCD_WDT_CODE)))
        else $error("watchdog restart not a one-cycle clear");
    a_wdt_status: assert property (wdt_clear_o |->
        expiry_bit_set_o && sleep_status_bit_set_o && !z_we_o)
        else $error("watchdog restart status bits wrong");
    a_dec_zero: assert property (accept && dif.is_dec |=>
        z_we_o && z_o == ($past(file_rdata_i) == CCD_ONE))
        else $error("decrement zero flag wrong");
    a_dec_to_w: assert property (
        accept && dif.is_dec && !dif.dest |=>
        w_we_o && !file_we_o && w_wdata_o == $past(file_rdata_i) - CCD_ONE)
        else $error("decrement to accumulator wrong");
    a_dec_to_file: assert property (
        accept && dif.is_dec && dif.dest |=>
        file_we_o && !w_we_o && file_wdata_o == $past(file_rdata_i) - CCD_ONE)
        else $error("decrement to file wrong");

endmodule : ccd_exec

`default_nettype wire

// [inc/ccd_pkg.sv]
package ccd_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CCD_INSTR_W = 14;
    localparam int CCD_DATA_W  = 8;
    localparam int CCD_FADDR_W = 7;
    localparam int CCD_TGT_W   = 11;
    localparam int CCD_PC_W    = 13;

    // ------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------
    localparam int                CCD_FCLR_LSB  = 7;
    localparam logic [6:0]        CCD_FCLR_OP   = 7'h03;
    localparam int                CCD_CALL_LSB  = 11;
    localparam logic [2:0]        CCD_CALL_OP   = 3'h4;
    localparam int                CCD_DEC_LSB   = 8;
    localparam logic [5:0]        CCD_DEC_OP    = 6'h03;
    localparam int                CCD_DEST_BIT  = 7;
    localparam logic [13:0]       CCD_WCLR_CODE = 14'h0103;
    localparam logic [13:0]       CCD_WDT_CODE  = 14'h0064;

    // ------------------------------------------------------------
    // Latch field and constants
    // ------------------------------------------------------------
    localparam int                CCD_LATCH_HI  = 4;
    localparam int                CCD_LATCH_LO  = 3;
    localparam logic [7:0]        CCD_ZERO      = 8'h00;
    localparam logic [7:0]        CCD_ONE       = 8'h01;
    localparam logic [12:0]       CCD_PC_ONE    = 13'h0001;

    // Execute state: accepting, or discarding the prefetched word
    typedef enum logic [1:0] {
        CCD_ST_EXEC  = 2'b01,
        CCD_ST_FLUSH = 2'b10
    } ccd_state_t;

endpackage : ccd_pkg

// [inc/ccd_dec_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Decoded instruction fields passed from decoder to execute stage
interface ccd_dec_if;
    logic        is_fclr;
    logic        is_call;
    logic        is_wclr;
    logic        is_wdt;
    logic        is_dec;
    logic        dest;
    logic [6:0]  faddr;
    logic [10:0] target;

    modport dec (output is_fclr, is_call, is_wclr, is_wdt, is_dec,
                 output dest, faddr, target);
    modport exe (input  is_fclr, is_call, is_wclr, is_wdt, is_dec,
                 input  dest, faddr, target);
endinterface : ccd_dec_if

`default_nettype wire

// [src/ccd_decode.sv]
`timescale 1ns/1ps
`default_nettype none

// Pattern decoder for the five handled opcodes
module ccd_decode
    import ccd_pkg::*;
(
    input  wire logic [ccd_pkg::CCD_INSTR_W-1:0] instr_i,
    ccd_dec_if.dec                               dif
);

    // ------------------------------------------------------------
    // Opcode match
    // ------------------------------------------------------------
    always_comb begin
        dif.is_fclr = (instr_i[13:CCD_FCLR_LSB] == CCD_FCLR_OP);
        dif.is_call = (instr_i[13:CCD_CALL_LSB] == CCD_CALL_OP);
        dif.is_wclr = (instr_i == CCD_WCLR_CODE);
        dif.is_wdt  = (instr_i == CCD_WDT_CODE);
        dif.is_dec  = (instr_i[13:CCD_DEC_LSB] == CCD_DEC_OP);
    end

    // ------------------------------------------------------------
    // Operand fields
    // ------------------------------------------------------------
    always_comb begin
        dif.faddr  = instr_i[CCD_FADDR_W-1:0];
        dif.dest   = instr_i[CCD_DEST_BIT];
        dif.target = instr_i[CCD_TGT_W-1:0];
    end

endmodule : ccd_decode

`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import ccd_pkg::*;

    typedef struct packed {
        logic [13:0] ins;
        logic [12:0] pc;
        logic [7:0]  lat;
        logic [7:0]  rd;
        logic [9:0]  stb;
        logic [7:0]  dat;
        logic        z;
        logic [12:0] tgt;
    } ccd_row_t;

    logic        ref_clk_i;
    logic        srst_i;
    logic        instr_valid_i;
    logic [13:0] instr_i;
    logic [12:0] pc_i;
    logic [7:0]  latch_i;
    logic [7:0]  file_rdata_i;
    logic        instr_ready_o;
    logic        file_we_o;
    logic [6:0]  file_addr_o;
    logic [7:0]  file_wdata_o;
    logic        w_we_o;
    logic [7:0]  w_wdata_o;
    logic        z_we_o;
    logic        z_o;
    logic        stack_push_o;
    logic [12:0] stack_top_o;
    logic        pc_load_o;
    logic [12:0] pc_target_o;
    logic        flush_o;
    logic        wdt_clear_o;
    logic        prescaler_clear_o;
    logic        expiry_bit_set_o;
    logic        sleep_status_bit_set_o;
    int          failures;
    int          samples_checked;
    ccd_row_t    rows [11];

    // ------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------
    ccd_exec u_dut (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i),
        .latch_i(latch_i), .file_rdata_i(file_rdata_i),
        .instr_ready_o(instr_ready_o), .file_we_o(file_we_o),
        .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
        .w_we_o(w_we_o), .w_wdata_o(w_wdata_o), .z_we_o(z_we_o),
        .z_o(z_o), .stack_push_o(stack_push_o), .stack_top_o(stack_top_o),
        .pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
        .flush_o(flush_o), .wdt_clear_o(wdt_clear_o),
        .prescaler_clear_o(prescaler_clear_o),
        .expiry_bit_set_o(expiry_bit_set_o),
        .sleep_status_bit_set_o(sleep_status_bit_set_o)
    );

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Cuts a hang short; the tests need about 40 cycles
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        failures++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // All strobes packed in one vector for one compare
    function automatic logic [9:0] strobes();
        return {file_we_o, w_we_o, z_we_o, stack_push_o, pc_load_o,
                flush_o, wdt_clear_o, prescaler_clear_o,
                expiry_bit_set_o, sleep_status_bit_set_o};
    endfunction : strobes

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    // Present one word at the falling edge, sample after the taking edge
    task automatic issue(input ccd_row_t r);
        @(negedge ref_clk_i);
        instr_valid_i = 1'b1;
        instr_i       = r.ins;
        pc_i          = r.pc;
        latch_i       = r.lat;
        file_rdata_i  = r.rd;
        @(posedge ref_clk_i);
        #1;
    endtask : issue

    task automatic idle();
        @(negedge ref_clk_i);
        instr_valid_i = 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask : idle

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        failures = 0;
        samples_checked = 0;
        srst_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_i = 14'h0000;
        pc_i = 13'h0000;
        latch_i = 8'h00;
        file_rdata_i = 8'h00;
        // Word, pc, latch, operand, strobes, data, zero, target
        rows[0]  = '{14'h01ff, 13'h0000, 8'h00, 8'h5a, 10'h280, 8'h00,
                     1'b1, 13'h0000};
        rows[1]  = '{14'h0180, 13'h0001, 8'h00, 8'hff, 10'h280, 8'h00,
                     1'b1, 13'h0000};
        rows[2]  = '{14'h0103, 13'h0002, 8'h00, 8'h00, 10'h180, 8'h00,
                     1'b1, 13'h0000};
        rows[3]  = '{14'h0064, 13'h0003, 8'h00, 8'h00, 10'h00f, 8'h00,
                     1'b0, 13'h0000};
        rows[4]  = '{14'h0385, 13'h0004, 8'h00, 8'h01, 10'h280, 8'h00,
                     1'b1, 13'h0000};
        rows[5]  = '{14'h037f, 13'h0005, 8'h00, 8'h00, 10'h180, 8'hff,
                     1'b0, 13'h0000};
        rows[6]  = '{14'h03aa, 13'h0006, 8'h00, 8'h80, 10'h280, 8'h7f,
                     1'b0, 13'h0000};
        rows[7]  = '{14'h27ff, 13'h1fff, 8'h18, 8'h00, 10'h070, 8'h00,
                     1'b0, 13'h1fff};
        rows[8]  = '{14'h2000, 13'h0abc, 8'he7, 8'h00, 10'h070, 8'h00,
                     1'b0, 13'h0000};
        rows[9]  = '{14'h22aa, 13'h0123, 8'h10, 8'h00, 10'h070, 8'h00,
                     1'b0, 13'h12aa};
        rows[10] = '{14'h2800, 13'h0200, 8'h18, 8'h00, 10'h000, 8'h00,
                     1'b0, 13'h0000};
        repeat (12) @(posedge ref_clk_i);
        #1;
        chk(strobes(), 10'h000);
        chk(instr_ready_o, 1'b1);
        @(negedge ref_clk_i);
        srst_i = 1'b0;
        $display("test reset done");
        // Table of ordinary cases, issued back to back except for an idle cycle after each call
        foreach (rows[i]) begin
            issue(rows[i]);
            chk(strobes(), rows[i].stb);
            if (rows[i].stb[9]) begin
                chk(file_addr_o, rows[i].ins[6:0]);
                chk(file_wdata_o, rows[i].dat);
            end
            if (rows[i].stb[8])
                chk(w_wdata_o, rows[i].dat);
            if (rows[i].stb[7])
                chk(z_o, rows[i].z);
            if (rows[i].stb[6]) begin
                chk(stack_top_o, 13'(rows[i].pc + 13'h0001));
                chk(pc_target_o, rows[i].tgt);
                chk(instr_ready_o, 1'b0);
                idle();
                chk(instr_ready_o, 1'b1);
                chk(strobes(), 10'h000);
            end
            $display("test row %0d done", i);
        end
        idle();
        chk(strobes(), 10'h000);
        // A word offered in the dead cycle after a call is ignored
        issue(rows[9]);
        chk(instr_ready_o, 1'b0);
        issue(rows[2]);
        chk(strobes(), 10'h000);
        idle();
        chk(strobes(), 10'h000);
        chk(instr_ready_o, 1'b1);
        $display("test dead cycle done");
        // Reset arriving with a call drops the call
        @(negedge ref_clk_i);
        srst_i = 1'b1;
        issue(rows[7]);
        chk(strobes(), 10'h000);
        chk(instr_ready_o, 1'b1);
        @(negedge ref_clk_i);
        srst_i = 1'b0;
        instr_valid_i = 1'b0;
        issue(rows[3]);
        chk(strobes(), 10'h00f);
        // Two restarts back to back keep the pulse up, then it drops
        issue(rows[3]);
        chk(strobes(), 10'h00f);
        idle();
        chk(strobes(), 10'h000);
        $display("test mid reset done");
        end_sim();
    end

endmodule : testbench

`default_nettype wire
